// file: design/scdt_pkg.sv
// constants and carrier types for the system clock divider and oscillator trim block
// assumes one undivided source clock and an axi4-lite register master
package scdt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses
  localparam logic [3:0] OFF_OSCILLATOR_TRIM       = 4'h0;
  localparam logic [3:0] OFF_CLOCK_DIVIDE_CONTROL  = 4'h4;

  ////////////////////////////////////////////////////////////////////////////
  // clock_divide_control fields
  localparam int         DIVCTL_UNLOCK_POS   = 7;
  localparam int         DIVCTL_RSVD_MSB     = 6;
  localparam int         DIVCTL_RSVD_LSB     = 4;
  localparam int         DIVCTL_SEL_MSB      = 3;
  localparam int         DIVCTL_SEL_LSB      = 0;

  // oscillator_trim fields
  localparam int         TRIM_RANGE_POS      = 7;
  localparam int         TRIM_FINE_MSB       = 6;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and limits
  localparam logic [3:0] SEL_RESET_PLAIN     = 4'h0;
  localparam logic [3:0] SEL_RESET_DIV8      = 4'h3;
  localparam logic [3:0] SEL_MAX_LEGAL       = 4'h8;
  localparam logic [2:0] UNLOCK_WINDOW       = 3'h4;
  localparam logic [7:0] CNT_RESET           = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // axi responses
  localparam logic [1:0] RESP_OKAY           = 2'h0;
  localparam logic [1:0] RESP_SLVERR         = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic       range_select_bit;
    logic [6:0] fine_trim_field;
  } scdt_trim_t;

  typedef struct packed {
    logic io_domain_clock;
    logic converter_domain_clock;
    logic core_domain_clock;
    logic program_memory_clock;
  } scdt_domain_en_t;

endpackage

// file: design/scdt_clock_divider.sv
// system clock divider with unlock-guarded select, clock output pin and oscillator trim
// assumes aclk is the undivided source clock, fuses are static levels, software on axi4-lite
`timescale 1ns/10ps

// How it works
// - clock-out fuse set: divided system clock replaces gpio on the output pin
// - with that fuse set the pin keeps toggling through reset
// - any factor above one puts the divided clock on the pin
// - all four domain enables share one divided tick
// - factor changes only at an old-period boundary, no short periods
// - divider counts at source rate; its count is never readable
// - new factor starts after the current old period completes
// - unlock is set only by a write with all other bits zero
// - unlock clears after four core cycles or on a select write
// - rewriting unlock while open neither extends nor clears the window
// - select code n divides by two to the n, codes 9..15 reserved
// - reset loads select 0 or 3 depending on divide-eight fuse
// - any legal select is accepted whatever the divide-eight fuse says
// - reset loads the factory calibration value into the trim register
// - software may rewrite the trim register at run time
// - trim top bit picks low or high oscillator range
// - lower seven trim bits tune monotonically within the range
module scdt_clock_divider #(
  parameter int ADDR_W = 4
) (
  // clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // fuses and factory data
  input  wire logic                   clock_out_fuse,
  input  wire logic                   start_divide_eight_fuse,
  input  wire logic [7:0]             trim_factory_value,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0]      s_axi_awaddr,
  input  wire logic [2:0]             s_axi_awprot,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  // axi4-lite write data and response
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0]      s_axi_araddr,
  input  wire logic [2:0]             s_axi_arprot,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // clock domain enables, one pulse per divided period
  output scdt_pkg::scdt_domain_en_t   domain_en,
  // oscillator trim to the rc oscillator
  output scdt_pkg::scdt_trim_t        trim_value,
  // shared clock output pin
  input  wire logic                   gpio_out,
  input  wire logic                   gpio_oe,
  output logic                        gpio_in,
  input  wire logic                   clock_out_pin_i,
  output logic                        clock_out_pin_o,
  output logic                        clock_out_pin_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [7:0] low_mask(input logic [3:0] n);
    low_mask = 8'((9'h001 << n) - 9'h001);
  endfunction

  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [3:0] off);
    addr_is = (a == ADDR_W'(off));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [7:0]                 cnt_q;
  logic [7:0]                 cnt_d;
  logic [3:0]                 act_sel_q;
  logic [3:0]                 act_sel_d;
  logic [3:0]                 divider_select_q;
  logic                       pend_q;
  logic                       lvl_q;
  logic                       lvl_d;
  logic                       divider_change_unlock_q;
  logic [2:0]                 win_q;
  logic [7:0]                 trim_q;
  logic                       bvalid_q;
  logic [1:0]                 bresp_q;
  logic                       rvalid_q;
  logic [1:0]                 rresp_q;
  logic [31:0]                rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // divider decode

  wire logic [7:0] cur_mask   = low_mask(act_sel_q);
  wire logic       tick       = ((cnt_q & cur_mask) == 8'h00);
  wire logic       last_cyc   = ((cnt_q & cur_mask) == cur_mask);
  wire logic       do_switch  = pend_q && last_cyc;

  // a counter with a single carry chain stands in for the ripple stages
  assign act_sel_d = do_switch ? divider_select_q : act_sel_q;
  assign cnt_d     = do_switch ? pkg_cnt_reset() : cnt_q + 8'h01;
  assign lvl_d     = (act_sel_d == 4'h0) ? 1'b1 : ~cnt_d[3'(act_sel_d - 4'h1)];

  function automatic logic [7:0] pkg_cnt_reset();
    pkg_cnt_reset = scdt_pkg::CNT_RESET;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  wire logic wr_go     = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  wire logic rd_go     = s_axi_arvalid && !rvalid_q;
  wire logic wr_trim   = addr_is(s_axi_awaddr, scdt_pkg::OFF_OSCILLATOR_TRIM);
  wire logic wr_ctl    = addr_is(s_axi_awaddr, scdt_pkg::OFF_CLOCK_DIVIDE_CONTROL);
  wire logic rd_trim   = addr_is(s_axi_araddr, scdt_pkg::OFF_OSCILLATOR_TRIM);
  wire logic rd_ctl    = addr_is(s_axi_araddr, scdt_pkg::OFF_CLOCK_DIVIDE_CONTROL);
  wire logic lane0     = s_axi_wstrb[0];

  wire logic trim_wr   = wr_go && wr_trim && lane0;
  wire logic ctl_wr    = wr_go && wr_ctl && lane0;
  wire logic [7:0] wb  = s_axi_wdata[7:0];
  wire logic unlock_bit = wb[scdt_pkg::DIVCTL_UNLOCK_POS];
  wire logic [3:0] sel_wdata = wb[scdt_pkg::DIVCTL_SEL_MSB:scdt_pkg::DIVCTL_SEL_LSB];

  // only a write with every other bit zero may open the window
  wire logic clean_set = ctl_wr && unlock_bit && (wb[6:0] == 7'h00);
  wire logic sel_wr    = ctl_wr && !unlock_bit && divider_change_unlock_q;
  wire logic sel_legal = (sel_wdata <= scdt_pkg::SEL_MAX_LEGAL);
  wire logic win_end   = divider_change_unlock_q && tick && (win_q == 3'h1);

  // reserved bits 6..4 read back as zero, the count itself never appears
  wire logic [7:0] ctl_view = {divider_change_unlock_q, 3'h0, divider_select_q};
  wire logic [7:0] rd_byte  = rd_trim ? trim_q : (rd_ctl ? ctl_view : 8'h00);

  ////////////////////////////////////////////////////////////////////////////
  // divider counter and active factor

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q     <= scdt_pkg::CNT_RESET;
      act_sel_q <= start_divide_eight_fuse ? scdt_pkg::SEL_RESET_DIV8 : scdt_pkg::SEL_RESET_PLAIN;
      lvl_q     <= 1'b1;
    end
    else
    begin
      cnt_q     <= cnt_d;
      act_sel_q <= act_sel_d;
      lvl_q     <= lvl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // select field and pending change

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      divider_select_q <= start_divide_eight_fuse ? scdt_pkg::SEL_RESET_DIV8 : scdt_pkg::SEL_RESET_PLAIN;
      pend_q           <= 1'b0;
    end
    else if (sel_wr && sel_legal)
    begin
      divider_select_q <= sel_wdata;
      pend_q           <= 1'b1;
    end
    else if (do_switch)
    begin
      pend_q           <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // unlock window, counted in core cycles

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      divider_change_unlock_q <= 1'b0;
      win_q                   <= 3'h0;
    end
    else if (!divider_change_unlock_q)
    begin
      if (clean_set)
      begin
        divider_change_unlock_q <= 1'b1;
        win_q                   <= scdt_pkg::UNLOCK_WINDOW;
      end
    end
    else if (sel_wr || win_end)
    begin
      divider_change_unlock_q <= 1'b0;
      win_q                   <= 3'h0;
    end
    else if (tick)
    begin
      // a second clean set is ignored here, so the window never stretches
      win_q <= win_q - 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // oscillator trim

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      trim_q <= trim_factory_value;
    end
    else if (trim_wr)
    begin
      trim_q <= wb;
    end
  end

  // bit 7 picks the range, the low seven tune within it
  assign trim_value.range_select_bit = trim_q[scdt_pkg::TRIM_RANGE_POS];
  assign trim_value.fine_trim_field  = trim_q[scdt_pkg::TRIM_FINE_MSB:0];

  ////////////////////////////////////////////////////////////////////////////
  // write channel

  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= scdt_pkg::RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= (wr_trim || wr_ctl) ? scdt_pkg::RESP_OKAY : scdt_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // read channel

  assign s_axi_arready = rd_go;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rresp_q  <= scdt_pkg::RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end
    else if (rd_go)
    begin
      rvalid_q <= 1'b1;
      rresp_q  <= (rd_trim || rd_ctl) ? scdt_pkg::RESP_OKAY : scdt_pkg::RESP_SLVERR;
      rdata_q  <= {24'h00_0000, rd_byte};
    end
    else if (s_axi_rready)
    begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp  = rresp_q;
  assign s_axi_rdata  = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // domain enables and clock output pin

  // one shared tick: no domain can drift from another
  assign domain_en.io_domain_clock        = aresetn && tick;
  assign domain_en.converter_domain_clock = aresetn && tick;
  assign domain_en.core_domain_clock      = aresetn && tick;
  assign domain_en.program_memory_clock   = aresetn && tick;

  // factor one passes the source through; the mux only flips while the
  // selected level is high, so no runt pulse reaches the pin
  wire logic sys_clk  = (act_sel_q == 4'h0) ? aclk : lvl_q;
  wire logic pin_clk  = !aresetn ? aclk : sys_clk;

  assign clock_out_pin_o  = clock_out_fuse ? pin_clk : gpio_out;
  assign clock_out_pin_oe = clock_out_fuse || gpio_oe;
  assign gpio_in          = clock_out_pin_i;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_open;
    !divider_change_unlock_q ##0 clean_set;
  endsequence

  sequence s_opened;
    divider_change_unlock_q && (win_q == scdt_pkg::UNLOCK_WINDOW);
  endsequence

  a_pin_override: assert property (
    clock_out_fuse |-> (clock_out_pin_oe && clock_out_pin_o == pin_clk))
    else $error("clock fuse set but pin not carrying the clock");

  a_domains_equal: assert property (
    domain_en.io_domain_clock == domain_en.core_domain_clock &&
    domain_en.converter_domain_clock == domain_en.program_memory_clock &&
    domain_en.core_domain_clock == tick)
    else $error("domain enables disagree");

  a_switch_boundary: assert property (
    (act_sel_q != $past(act_sel_q)) |-> $past(last_cyc) && cnt_q == scdt_pkg::CNT_RESET)
    else $error("factor changed inside a period");

  a_div2_period: assert property (
    (act_sel_q == 4'h1 && tick && !pend_q) |=> !tick ##1 tick)
    else $error("divide by two period wrong");

  a_unlock_clean: assert property (
    (ctl_wr && !divider_change_unlock_q && !clean_set) |=> !divider_change_unlock_q)
    else $error("unlock set by a dirty write");

  a_unlock_open: assert property (
    s_open |=> s_opened)
    else $error("clean write did not open the window");

  a_unlock_timeout: assert property (
    win_end && !sel_wr |=> !divider_change_unlock_q)
    else $error("unlock outlived four core cycles");

  a_unlock_select_clr: assert property (
    sel_wr |=> !divider_change_unlock_q && win_q == 3'h0)
    else $error("select write left unlock set");

  // a rewrite only lets the window run down by the normal tick count
  a_unlock_no_extend: assert property (
    (divider_change_unlock_q && clean_set && !win_end) |=>
      divider_change_unlock_q && (win_q == $past(win_q) - {2'h0, $past(tick)}))
    else $error("rewrite of unlock changed the window");

  a_reserved_ignored: assert property (
    (sel_wr && !sel_legal && !pend_q) |=> $stable(divider_select_q) && !pend_q)
    else $error("reserved select code accepted");

  a_select_taken: assert property (
    (sel_wr && sel_legal) |=> divider_select_q == $past(sel_wdata) && pend_q)
    else $error("legal select code not taken");

  a_reset_select: assert property (
    $rose(aresetn) |-> divider_select_q ==
      ($past(start_divide_eight_fuse) ? scdt_pkg::SEL_RESET_DIV8 : scdt_pkg::SEL_RESET_PLAIN))
    else $error("select reset value wrong");

  a_reset_trim: assert property (
    $rose(aresetn) |-> trim_q == $past(trim_factory_value))
    else $error("trim not loaded with factory value");

  a_write_resp: assert property (
    wr_go |=> s_axi_bvalid)
    else $error("write response missing");

endmodule

// file: bench/test_system_clock_divider_trim.sv
// self-checking bench for the clock divider and trim block
// assumes the design package is compiled first; drives axi4-lite, fuses and pin
`timescale 1ns/10ps

module test_system_clock_divider_trim;
  typedef struct packed {
    logic [1:0]  resp;
    logic [31:0] data;
  } scdt_exp_t;

  localparam logic [3:0] OSC = scdt_pkg::OFF_OSCILLATOR_TRIM;
  localparam logic [3:0] CTL = scdt_pkg::OFF_CLOCK_DIVIDE_CONTROL;
  localparam logic [1:0] OK  = scdt_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = scdt_pkg::RESP_SLVERR;

  logic                      aclk, aresetn, ck_fuse, d8_fuse;
  logic [7:0]                fact, t;
  logic [3:0]                awaddr, araddr, wstrb;
  logic [31:0]               wdata;
  logic                      awvalid, wvalid, bready, arvalid, rready;
  logic                      awready, wready, bvalid, arready, rvalid;
  logic [1:0]                bresp, rresp;
  logic [31:0]               rdata;
  scdt_pkg::scdt_domain_en_t den;
  scdt_pkg::scdt_trim_t      trim;
  logic                      gpo, gpoe, gpi, pin_i, pin_o, pin_oe;
  scdt_exp_t                 wq[$], rq[$], ew, er;
  int                        error_cnt, comparisons, cur, s;

  scdt_clock_divider u_scdt_clock_divider (
    .aclk(aclk), .aresetn(aresetn), .clock_out_fuse(ck_fuse), .start_divide_eight_fuse(d8_fuse),
    .trim_factory_value(fact), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .domain_en(den), .trim_value(trim), .gpio_out(gpo), .gpio_oe(gpoe), .gpio_in(gpi),
    .clock_out_pin_i(pin_i), .clock_out_pin_o(pin_o), .clock_out_pin_oe(pin_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // reporting
  task automatic fail(string m);
    error_cnt++;
    $display("unexpected at %0t: %s", $time, m);
  endtask

  task automatic cmp_val(logic [31:0] g, logic [31:0] e, string m);
    comparisons++;
    if (g !== e) fail(m);
  endtask

  task automatic cmp_cnt(int g, int e, string m);
    comparisons++;
    if (g != e) fail(m);
  endtask

  task automatic close_out;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // response watcher, takes the oldest note per answer
  always @(posedge aclk)
  begin
    if (bvalid === 1'b1 && bready === 1'b1)
    begin
      if (wq.size() == 0) fail("write response without request");
      else
      begin
        ew = wq.pop_front();
        cmp_val({30'h0, bresp}, {30'h0, ew.resp}, "write response code");
      end
    end
    if (rvalid === 1'b1 && rready === 1'b1)
    begin
      if (rq.size() == 0) fail("read data without request");
      else
      begin
        er = rq.pop_front();
        cmp_val({30'h0, rresp}, {30'h0, er.resp}, "read response code");
        cmp_val(rdata, er.data, "read data");
      end
    end
  end

  // all four domain enables move together
  always @(negedge aclk)
    if (aresetn === 1'b1)
      cmp_val({28'h0, den}, (den === 4'h0) ? 32'h0 : 32'hf, "domain enables differ");

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite master, one transfer at a time
  task automatic wr(logic [3:0] a, logic [7:0] d, logic [1:0] r, logic [3:0] st = 4'hf);
    wq.push_back('{r, 32'h0});
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'($urandom()), d};
    wstrb   <= st;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    // no limit here: only the watchdog may end a wait
    do @(posedge aclk); while (!(awready === 1'b1 && wready === 1'b1));
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    bready  <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready  <= 1'b0;
  endtask

  task automatic rd(logic [3:0] a, logic [7:0] d, logic [1:0] r);
    rq.push_back('{r, {24'h0, d}});
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready  <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // divider helpers
  task automatic tick(output int n);
    n = 0;
    do begin @(posedge aclk); #1; n++; end while (den === 4'h0 && n < 600);
  endtask

  // unlock then select; at factor one the select lands on the third of the four ticks, one tick before the window closes
  task automatic setdiv(logic [3:0] c);
    wr(CTL, 8'h80, OK);
    wr(CTL, {4'h0, c}, OK);
  endtask

  // settle gaps never shorter than the shorter of the two periods, then one full period
  task automatic per(int c, bit pin);
    int n, hi, p, m, ok;
    p  = 1 << c;
    m  = (p < (1 << cur)) ? p : (1 << cur);
    tick(n);
    tick(n);
    ok = (n >= m);
    tick(n);
    ok = ok & (n >= m);
    cmp_cnt(ok, 1, "short clock period while switching");
    hi = 0;
    n  = 0;
    do begin @(posedge aclk); #1; n++; hi += (pin_o === 1'b1); end while (den === 4'h0 && n < 600);
    cmp_cnt(n, p, "divided period");
    if (pin) cmp_cnt(hi, (p == 1) ? 1 : p / 2, "clock pin high time");
    cur = c;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // stimulus
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  initial
  begin
    repeat (60000) @(posedge aclk);
    fail("watchdog expired");
    close_out;
  end

  initial
  begin
    s = $urandom(22);
    error_cnt = 0; comparisons = 0; cur = 3;
    aresetn = 1'b0; ck_fuse = 1'b1; d8_fuse = 1'b1; fact = 8'($urandom());
    awaddr = 4'h0; araddr = 4'h0; wdata = 32'h0; wstrb = 4'hf;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    gpo = 1'b0; gpoe = 1'b0; pin_i = 1'b0;
    repeat (8) @(posedge aclk);
    #1 cmp_val({31'h0, pin_o}, 32'h1, "pin low after rising edge in reset");
    @(negedge aclk);
    #1 cmp_val({31'h0, pin_o}, 32'h0, "pin high after falling edge in reset");
    cmp_val({31'h0, pin_oe}, 32'h1, "pin not driven with fuse set");
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OSC, fact, OK);
    rd(CTL, 8'h03, OK);
    per(3, 1);
    t = 8'($urandom());
    wr(OSC, t, OK);
    rd(OSC, t, OK);
    cmp_val({24'h0, trim}, {24'h0, t}, "trim output");
    wr(OSC, ~t, OK, 4'he);
    rd(OSC, t, OK);
    wr(4'h8, 8'h55, ERR);
    rd(4'hc, 8'h00, ERR);
    wr(CTL, 8'h80, OK);
    rd(CTL, 8'h83, OK);
    wr(CTL, 8'h01, OK);
    rd(CTL, 8'h01, OK);
    per(1, 1);
    for (int c = 0; c <= 8; c++)
    begin
      setdiv(4'(c));
      rd(CTL, 8'(c), OK);
      per(c, 1);
    end
    setdiv(4'h2);
    per(2, 1);
    setdiv(4'hc);
    rd(CTL, 8'h02, OK);
    per(2, 1);
    wr(CTL, 8'h81, OK);
    wr(CTL, 8'h05, OK);
    wr(CTL, 8'h70, OK);
    rd(CTL, 8'h02, OK);
    setdiv(4'h0);
    per(0, 1);
    wr(CTL, 8'h80, OK);
    repeat (8) @(posedge aclk);
    wr(CTL, 8'h05, OK);
    rd(CTL, 8'h00, OK);
    wr(CTL, 8'h80, OK);
    wr(CTL, 8'h80, OK);
    wr(CTL, 8'h05, OK);
    rd(CTL, 8'h00, OK);
    // second reset with both fuses clear; pin belongs to the port logic
    @(posedge aclk);
    aresetn <= 1'b0;
    ck_fuse <= 1'b0;
    d8_fuse <= 1'b0;
    fact    <= 8'($urandom());
    repeat (8)
    begin
      @(posedge aclk);
      gpo   <= 1'($urandom());
      gpoe  <= 1'($urandom());
      pin_i <= 1'($urandom());
      @(negedge aclk);
      cmp_val({29'h0, pin_o, pin_oe, gpi}, {29'h0, gpo, gpoe, pin_i}, "pin with fuse clear");
    end
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    cur = 0;
    rd(CTL, 8'h00, OK);
    rd(OSC, fact, OK);
    per(0, 0);
    setdiv(4'h1);
    per(1, 0);
    repeat (4) @(posedge aclk);
    cmp_cnt(wq.size() + rq.size(), 0, "responses missing");
    close_out;
  end
endmodule
